/* design/cavs_cfg.svh */
// Purpose: Constants for the character attribute video serializer
// Assumes: Included by its bare name from the design files
// Notes: Row masks hold one bit per raster row, bit n for row n
`ifndef CAVS_CFG_SVH
`define CAVS_CFG_SVH

`define CAVS_CODE_W 8
`define CAVS_ROW_W 4
`define CAVS_SR_W 8
`define CAVS_SYNC_W 25
`define CAVS_FIFO_DEPTH 16
// Cursor divisor in frames; character divisor is twice this
`define CAVS_CUR_DIV 16
`define CAVS_CUR_DIV_MIN 4
`define CAVS_CUR_DIV_MAX 62
`define CAVS_CUR_STYLE 2'h3
`define CAVS_UL_ROWS 16'h0800
`define CAVS_ST_ROWS 16'h0060
`define CAVS_THIN_END 4'hB
`define CAVS_THIN_HROW 4'h5
`define CAVS_GLYPH_TOP 4'h1
`define CAVS_GLYPH_BOT 4'hB
`define CAVS_ALL_ON 8'hFF
`define CAVS_ALL_OFF 8'h00
`define CAVS_GLYPH_SIDES 7'h41

`endif

/* design/cavs_pkg.sv */
// Purpose: Types for the character attribute video serializer
// Assumes: Constants live in cavs_cfg.svh
// Notes: Record is what one load-shift fall captures
package cavs_pkg;

    typedef enum logic [1:0] {
        CAVS_WIDE  = 2'b00,
        CAVS_THIN  = 2'b01,
        CAVS_EXT   = 2'b10,
        CAVS_ALPHA = 2'b11
    } cavs_mode_t;

    typedef enum logic [1:0] {
        CAVS_CUR_UL   = 2'b00,
        CAVS_CUR_BUL  = 2'b01,
        CAVS_CUR_REV  = 2'b10,
        CAVS_CUR_BREV = 2'b11
    } cavs_cur_t;

    typedef struct packed {
        logic [7:0] code;
        logic [3:0] row;
        cavs_mode_t mode;
        logic rev;
        logic blank;
        logic blink;
        logic ul;
        logic st;
        logic retr;
        logic cur;
    } cavs_rec_t;

endpackage

/* design/cavs_top.sv */
// Purpose: Turns character codes and attributes into a serial dot stream
// Assumes: Dot clock, load-shift and vsync are slow pins sampled on ref_clk
// Notes: Dot clock must stay below a quarter of ref_clk
//
// What this block does
// - Load-shift low: each dot clock shifts the 8-bit register one place.
// - Load-shift high: next dot clock loads in parallel, output held.
// - Code inputs captured on the falling edge of load-shift.
// - After a load, C7 leaves first, then C6 down to C0.
// - After C0, backfill zeros, or ones under reverse video, until reload.
// - Mode 11 picks one of 128 glyphs by low seven bits and row.
// - Glyph rows 0 and 12 to 15 and column C7 are zero.
// - Mode 01 uses three low bits as segments, from row 0 to end row.
// - Wide graphics: eight code bits drive eight block segments.
// - External mode passes the code word itself as the row pattern.
// - A 4-bit raster row input selects the row in the block.
// - Attribute enable high latches attributes on load-shift fall, else hold.
// - Strike-through forces the strike rows high; reverse then applies.
// - Underline forces the underline rows high; reverse then applies.
// - Reverse video low passes the pattern, high inverts it.
// - Character blank drives all low, beats blink; reverse then applies.
// - Vsync clocks two blink dividers, cursor 50/50, character twice, 75/25.
// - Blink blanks the block in the character blink off phase, or in the cursor off phase at the cursor.
// - Mode may change per character and applies to that character alone.
// - All attributes work in all four display modes.
// - Retrace blank latched high loads all zeros regardless of attributes.
// - Mode 10 is external, mode 00 is wide graphics.
// - Cursor applies one fixed style of four; default blinking reverse.
`timescale 1ns/1ps
`include "cavs_cfg.svh"

module cavs_fifo #(
    parameter int W = 21,
    parameter int DEPTH = `CAVS_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [W-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != FULL_CNT);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule

module cavs_top import cavs_pkg::*; #(
    parameter int CURSOR_DIVISOR = `CAVS_CUR_DIV,
    parameter cavs_cur_t CURSOR_STYLE = cavs_cur_t'(`CAVS_CUR_STYLE),
    parameter logic [15:0] UL_ROWS = `CAVS_UL_ROWS,
    parameter logic [15:0] ST_ROWS = `CAVS_ST_ROWS,
    parameter logic [3:0] THIN_END = `CAVS_THIN_END,
    parameter logic [3:0] THIN_HROW = `CAVS_THIN_HROW,
    parameter int FIFO_DEPTH = `CAVS_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic dot_shift_clock,
    input wire logic load_shift_select,
    input wire logic [`CAVS_CODE_W-1:0] char_code_in,
    input wire logic [`CAVS_ROW_W-1:0] raster_row_in,
    input wire logic attribute_latch_enable,
    input wire logic strike_line_in,
    input wire logic under_line_in,
    input wire logic invert_video_in,
    input wire logic char_blank_in,
    input wire logic blink_in,
    input wire logic glyph_mode_select_lo,
    input wire logic glyph_mode_select_hi,
    input wire logic retrace_blank_in,
    input wire logic cursor_in,
    input wire logic vsync_in,
    output logic video_out,
    output logic char_fifo_ready,
    output logic char_underrun
);
    localparam int RW = $bits(cavs_rec_t);
    localparam logic [6:0] CUR_DIV = 7'(CURSOR_DIVISOR);
    localparam logic [6:0] CUR_HALF = 7'(CURSOR_DIVISOR / 2);
    localparam logic [6:0] CHAR_DIV = 7'(2 * CURSOR_DIVISOR);
    localparam logic [6:0] CHAR_ON = 7'(3 * CURSOR_DIVISOR / 2);

    // Glyph ROM stand-in: a box with the code in its middle rows
    function automatic logic [7:0] glyph_row(input logic [6:0] c,
                                             input logic [3:0] r);
        if (r < `CAVS_GLYPH_TOP || r > `CAVS_GLYPH_BOT) begin
            return `CAVS_ALL_OFF;
        end else if (r == `CAVS_GLYPH_TOP || r == `CAVS_GLYPH_BOT) begin
            return {1'b0, 7'h7F};
        end else begin
            return {1'b0, c | `CAVS_GLYPH_SIDES};
        end
    endfunction

    function automatic logic [7:0] thin_row(input logic [2:0] c,
                                            input logic [3:0] r);
        logic [7:0] v;
        v = `CAVS_ALL_OFF;
        if (r <= THIN_END) begin
            v[4] = c[0];
            if (r == THIN_HROW) begin
                v[7:4] = {4{c[1]}} | v[7:4];
                v[3:0] = {4{c[2]}};
            end
        end
        return v;
    endfunction

    function automatic logic [7:0] wide_row(input logic [7:0] c,
                                            input logic [3:0] r);
        logic left;
        logic right;
        left = c[{r[3:2], 1'b1}];
        right = c[{r[3:2], 1'b0}];
        return {{4{left}}, {4{right}}};
    endfunction

    function automatic logic row_hit(input logic [15:0] mask,
                                     input logic [3:0] r);
        return mask[r];
    endfunction

    logic [`CAVS_SYNC_W-1:0] pins_in;
    logic [`CAVS_SYNC_W-1:0] s1_reg;
    logic [`CAVS_SYNC_W-1:0] s2_reg;
    logic [2:0] prev_reg;
    logic dot_s, ldsh_s, ate_s, vs_s;
    logic [7:0] code_s;
    logic [3:0] row_s;
    logic [6:0] attr_in;
    logic [6:0] attr_now;
    logic [6:0] attr_reg;
    logic dot_rise, ldsh_rise, ldsh_fall, vs_rise;
    logic load_pend_reg;
    logic do_load, shift_tick;
    cavs_rec_t rec_in, rec;
    logic f_in_ready, f_out_valid;
    logic [RW-1:0] f_out_data;
    logic [6:0] div_cnt_reg;
    logic [6:0] cur_cnt;
    logic cur_phase, char_phase;
    logic [7:0] raw, attr_pat, pat_d;
    logic uhit, shit, cur_ul, rev_eff, blink_off, fill_d;
    logic [7:0] shreg_reg;
    logic fill_reg, video_reg, ready_reg, underrun_reg;

    assign pins_in = {vsync_in, cursor_in, retrace_blank_in,
                      glyph_mode_select_hi, glyph_mode_select_lo,
                      blink_in, char_blank_in, invert_video_in,
                      under_line_in, strike_line_in,
                      attribute_latch_enable, raster_row_in,
                      char_code_in, load_shift_select, dot_shift_clock};

    // All pins are asynchronous to ref_clk
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= pins_in;
            s2_reg <= s1_reg;
        end
    end

    assign dot_s = s2_reg[0];
    assign ldsh_s = s2_reg[1];
    assign code_s = s2_reg[9:2];
    assign row_s = s2_reg[13:10];
    assign ate_s = s2_reg[14];
    assign attr_in = {s2_reg[21:20], s2_reg[17], s2_reg[18],
                      s2_reg[19], s2_reg[16], s2_reg[15]};
    assign vs_s = s2_reg[24];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= {vs_s, ldsh_s, dot_s};
        end
    end

    assign dot_rise = dot_s && !prev_reg[0];
    assign ldsh_rise = ldsh_s && !prev_reg[1];
    assign ldsh_fall = !ldsh_s && prev_reg[1];
    assign vs_rise = vs_s && !prev_reg[2];

    // Attribute latch: {mode, rev, blank, blink, ul, st}
    assign attr_now = ate_s ? attr_in : attr_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            attr_reg <= '0;
        end else if (ldsh_fall && ate_s) begin
            attr_reg <= attr_in;
        end
    end

    // Each record carries its own mode, so modes mix per character
    assign rec_in = '{code: code_s, row: row_s,
                      mode: cavs_mode_t'(attr_now[6:5]),
                      rev: attr_now[4], blank: attr_now[3],
                      blink: attr_now[2], ul: attr_now[1],
                      st: attr_now[0], retr: s2_reg[22],
                      cur: s2_reg[23]};

    // Decouples capture from load; a full queue drops the character
    cavs_fifo #(.W(RW), .DEPTH(FIFO_DEPTH)) cavs_fifo_i (
        .clk(ref_clk),
        .rst(rst),
        .in_valid(ldsh_fall),
        .in_data(rec_in),
        .in_ready(f_in_ready),
        .out_valid(f_out_valid),
        .out_data(f_out_data),
        .out_ready(do_load)
    );

    // One load per high period of load-shift
    assign do_load = dot_rise && ldsh_s && (load_pend_reg || ldsh_rise);
    assign shift_tick = dot_rise && !ldsh_s;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            load_pend_reg <= 1'b0;
        end else if (do_load) begin
            load_pend_reg <= 1'b0;
        end else if (ldsh_rise) begin
            load_pend_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= '0;
        end else if (vs_rise) begin
            div_cnt_reg <= (div_cnt_reg >= CHAR_DIV - 7'h01) ? '0 :
                           div_cnt_reg + 7'h01;
        end
    end

    assign cur_cnt = (div_cnt_reg >= CUR_DIV) ? div_cnt_reg - CUR_DIV :
                     div_cnt_reg;
    assign cur_phase = cur_cnt < CUR_HALF;
    assign char_phase = div_cnt_reg < CHAR_ON;

    assign rec = cavs_rec_t'(f_out_data);

    always_comb begin
        case (rec.mode)
            CAVS_ALPHA: raw = glyph_row(rec.code[6:0], rec.row);
            CAVS_THIN: raw = thin_row(rec.code[2:0], rec.row);
            CAVS_WIDE: raw = wide_row(rec.code, rec.row);
            CAVS_EXT: raw = rec.code;
            default: raw = `CAVS_ALL_OFF;
        endcase
    end

    assign uhit = row_hit(UL_ROWS, rec.row);
    assign shit = row_hit(ST_ROWS, rec.row);
    assign cur_ul = rec.cur && uhit &&
                    (CURSOR_STYLE == CAVS_CUR_UL ||
                     (CURSOR_STYLE == CAVS_CUR_BUL && cur_phase));
    assign rev_eff = rec.rev ^ (rec.cur &&
                     (CURSOR_STYLE == CAVS_CUR_REV ||
                      (CURSOR_STYLE == CAVS_CUR_BREV && cur_phase)));
    // A cursor moves a blinking character to the cursor rate
    assign blink_off = rec.blink && !(rec.cur ? cur_phase : char_phase);

    // Same order in every mode: force, blank, cursor, invert
    always_comb begin
        attr_pat = raw;
        if (rec.ul && uhit) begin
            attr_pat = `CAVS_ALL_ON;
        end
        if (rec.st && shit) begin
            attr_pat = `CAVS_ALL_ON;
        end
        if (blink_off) begin
            attr_pat = `CAVS_ALL_OFF;
        end
        if (rec.blank) begin
            attr_pat = `CAVS_ALL_OFF;
        end
        if (cur_ul) begin
            attr_pat = `CAVS_ALL_ON;
        end
        if (rev_eff) begin
            attr_pat = ~attr_pat;
        end
        if (rec.retr) begin
            attr_pat = `CAVS_ALL_OFF;
        end
    end

    // Empty queue at load time shows a blank cell
    assign pat_d = f_out_valid ? attr_pat : `CAVS_ALL_OFF;
    assign fill_d = f_out_valid && rev_eff && !rec.retr;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shreg_reg <= '0;
            fill_reg <= 1'b0;
            video_reg <= 1'b0;
        end else if (do_load) begin
            shreg_reg <= pat_d;
            fill_reg <= fill_d;
        end else if (shift_tick) begin
            shreg_reg <= {shreg_reg[6:0], fill_reg};
            video_reg <= shreg_reg[7];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ready_reg <= 1'b0;
            underrun_reg <= 1'b0;
        end else begin
            ready_reg <= f_in_ready;
            underrun_reg <= do_load && !f_out_valid;
        end
    end

    assign video_out = video_reg;
    assign char_fifo_ready = ready_reg;
    assign char_underrun = underrun_reg;

    // Checking aid: expected dot stream after each load
    logic [7:0] chk_pat_reg;
    logic chk_fill_reg;
    logic [3:0] chk_n_reg;
    logic chk_bit;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chk_pat_reg <= '0;
            chk_fill_reg <= 1'b0;
            chk_n_reg <= 4'h8;
        end else if (do_load) begin
            chk_pat_reg <= pat_d;
            chk_fill_reg <= fill_d;
            chk_n_reg <= '0;
        end else if (shift_tick && chk_n_reg != 4'h8) begin
            chk_n_reg <= chk_n_reg + 4'h1;
        end
    end

    assign chk_bit = chk_pat_reg[3'h7 - chk_n_reg[2:0]];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_load;
        do_load;
    endsequence

    sequence s_held_load;
        $stable(video_reg) && shreg_reg == $past(pat_d);
    endsequence

    a_shift_one_place:
        assert property (shift_tick |=> shreg_reg[0] == $past(fill_reg)
                         && video_reg == $past(shreg_reg[7]))
        else $error("shift did not move one place");

    a_load_holds_video:
        assert property (s_load |=> s_held_load)
        else $error("parallel load wrong or video moved");

    a_code_captured:
        assert property (ldsh_fall && f_in_ready |=> f_out_valid)
        else $error("code not captured on load-shift fall");

    a_columns_in_order:
        assert property (shift_tick && chk_n_reg < 4'h8
                         |=> video_reg == $past(chk_bit))
        else $error("column order wrong");

    a_backfill_value:
        assert property (shift_tick && chk_n_reg == 4'h8
                         |=> video_reg == $past(chk_fill_reg))
        else $error("backfill value wrong");

    a_glyph_border_zero:
        assert property (rec.mode == CAVS_ALPHA |-> raw[7] == 1'b0 &&
                         (rec.row != 4'h0 && rec.row < 4'hC ||
                          raw == `CAVS_ALL_OFF))
        else $error("glyph border not zero");

    a_attr_held:
        assert property (ldsh_fall && !ate_s |=> $stable(attr_reg))
        else $error("attributes changed while latch disabled");

    a_underline_forced:
        assert property (f_out_valid && rec.ul && uhit && !rec.retr &&
                         !rec.blank && !blink_off && !rev_eff
                         |-> pat_d == `CAVS_ALL_ON)
        else $error("underline row not forced high");

    a_blank_low:
        assert property (f_out_valid && rec.blank && !cur_ul &&
                         !rev_eff |-> pat_d == `CAVS_ALL_OFF)
        else $error("blank character not low");

    a_divider_wraps:
        assert property (vs_rise && div_cnt_reg == CHAR_DIV - 7'h01
                         |=> div_cnt_reg == '0 ##1 div_cnt_reg < CHAR_DIV)
        else $error("blink divider wrap wrong");

    a_retrace_zero:
        assert property (do_load && f_out_valid && rec.retr
                         |=> shreg_reg == `CAVS_ALL_OFF && !fill_reg)
        else $error("retrace did not blank");
endmodule

/* tb/cavs_ctrl_model.sv */
// Purpose: Display timing controller model, load-shift and dot clock
// Assumes: Pins move on the falling edge of ref_clk
// Notes: Every level is held at least four ref_clk cycles, above the sync minimum
`timescale 1ns/1ps
module cavs_ctrl_model (
    input wire logic ref_clk,
    input wire logic video_out,
    output logic dot_shift_clock,
    output logic load_shift_select
);
    // Dot clock stands low outside character times
    initial begin
        dot_shift_clock = 1'b0;
        load_shift_select = 1'b0;
    end

    task automatic hold4;
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic dot;
        dot_shift_clock = 1'b1;
        hold4();
        dot_shift_clock = 1'b0;
        hold4();
    endtask

    // Capture only; no dot while high, so nothing leaves the queue
    task automatic push_only;
        load_shift_select = 1'b1;
        hold4();
        load_shift_select = 1'b0;
        hold4();
    endtask

    // Load, capture, then ten shifts sampled just before the next rise
    task automatic char_time(output logic [9:0] bits);
        int i;
        load_shift_select = 1'b1;
        hold4();
        dot();
        load_shift_select = 1'b0;
        hold4();
        for (i = 9; i >= 0; i--) begin
            dot();
            bits[i] = video_out;
        end
    endtask
endmodule

/* tb/test_char_attr_video_serializer.sv */
// Purpose: Self-checking bench for the video serializer
// Assumes: Controller model owns load-shift and dot clock
// Notes: Each load shows the oldest queued record, captured one character earlier except in s_fifo
`timescale 1ns/1ps
module test_char_attr_video_serializer import cavs_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ale = 1'b1;
    logic vsync = 1'b0;
    logic retr = 1'b0;
    logic cur = 1'b0;
    logic [7:0] code = 8'h00;
    logic [3:0] row = 4'h0;
    // Attribute bits: reverse, blank, blink, underline, strike
    logic [4:0] att = 5'h00;
    cavs_mode_t mode = CAVS_EXT;
    logic dot_clk;
    logic ld_sel;
    logic video;
    logic ready;
    logic under;
    int n_errors = 0;
    int comparisons = 0;
    int n_under = 0;

    cavs_top cavs_top_i (
        .ref_clk(ref_clk), .rst(rst), .dot_shift_clock(dot_clk),
        .load_shift_select(ld_sel), .char_code_in(code),
        .raster_row_in(row), .attribute_latch_enable(ale),
        .strike_line_in(att[0]), .under_line_in(att[1]),
        .invert_video_in(att[4]), .char_blank_in(att[3]),
        .blink_in(att[2]), .glyph_mode_select_lo(mode[0]),
        .glyph_mode_select_hi(mode[1]), .retrace_blank_in(retr),
        .cursor_in(cur), .vsync_in(vsync), .video_out(video),
        .char_fifo_ready(ready), .char_underrun(under)
    );

    cavs_ctrl_model cavs_ctrl_model_i (
        .ref_clk(ref_clk), .video_out(video),
        .dot_shift_clock(dot_clk), .load_shift_select(ld_sel)
    );

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        if (under === 1'b1) n_under++;
    end

    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic ok(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Queue the next record and check the one loaded before it
    task automatic st(input logic [7:0] c, input logic [3:0] r,
        input cavs_mode_t m, input logic [4:0] a, input logic [9:0] e);
        logic [9:0] b;
        code = c;
        row = r;
        mode = m;
        att = a;
        cavs_ctrl_model_i.char_time(b);
        ok(b, e);
    endtask

    task automatic vs(input int n);
        repeat (n) begin
            vsync = 1'b1;
            repeat (4) @(negedge ref_clk);
            vsync = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
    endtask

    task automatic s_reset;
        int i;
        ok({9'h000, video}, 10'h000);
        ok({9'h000, under}, 10'h000);
        for (i = 0; i < 8 && ready !== 1'b1; i++) @(negedge ref_clk);
        ok({9'h000, ready}, 10'h001);
        if (ready !== 1'b1) test_done();
    endtask

    task automatic s_ext;
        st(8'hA5, 4'h0, CAVS_EXT, 5'h00, 10'h000);
        st(8'hA5, 4'h0, CAVS_EXT, 5'h10, {8'hA5, 2'h0});
        st(8'h00, 4'h0, CAVS_EXT, 5'h00, {8'h5A, 2'h3});
        ok(10'(n_under), 10'h001);
    endtask

    task automatic s_alpha;
        st(8'h80, 4'h5, CAVS_ALPHA, 5'h00, {8'h00, 2'h0});
        st(8'h33, 4'h1, CAVS_ALPHA, 5'h00, {8'h41, 2'h0});
        st(8'h33, 4'hC, CAVS_ALPHA, 5'h00, {8'h7F, 2'h0});
        st(8'h0A, 4'h7, CAVS_ALPHA, 5'h00, {8'h00, 2'h0});
        st(8'h01, 4'h0, CAVS_THIN, 5'h00, {8'h4B, 2'h0});
    endtask

    task automatic s_graph;
        st(8'h07, 4'h5, CAVS_THIN, 5'h00, {8'h10, 2'h0});
        st(8'h07, 4'hC, CAVS_THIN, 5'h00, {8'hFF, 2'h0});
        st(8'h02, 4'h0, CAVS_WIDE, 5'h00, {8'h00, 2'h0});
        st(8'h80, 4'hF, CAVS_WIDE, 5'h00, {8'hF0, 2'h0});
        st(8'h40, 4'hF, CAVS_WIDE, 5'h00, {8'hF0, 2'h0});
        st(8'h10, 4'h8, CAVS_WIDE, 5'h00, {8'h0F, 2'h0});
    endtask

    task automatic s_attr;
        st(8'h00, 4'hB, CAVS_EXT, 5'h02, {8'h0F, 2'h0});
        st(8'h00, 4'h4, CAVS_EXT, 5'h02, {8'hFF, 2'h0});
        st(8'h00, 4'h5, CAVS_ALPHA, 5'h01, {8'h00, 2'h0});
        st(8'h00, 4'h6, CAVS_WIDE, 5'h11, {8'hFF, 2'h0});
        st(8'hFF, 4'h0, CAVS_EXT, 5'h08, {8'h00, 2'h3});
        st(8'hFF, 4'h0, CAVS_EXT, 5'h18, {8'h00, 2'h0});
        retr = 1'b1;
        st(8'hAA, 4'hB, CAVS_EXT, 5'h12, {8'hFF, 2'h3});
        retr = 1'b0;
        st(8'hAA, 4'h0, CAVS_EXT, 5'h00, {8'h00, 2'h0});
    endtask

    // Attribute enable low must keep the previous mode and reverse
    task automatic s_latch;
        ale = 1'b0;
        st(8'h55, 4'h0, CAVS_ALPHA, 5'h10, {8'hAA, 2'h0});
        ale = 1'b1;
        st(8'h00, 4'h0, CAVS_EXT, 5'h00, {8'h55, 2'h0});
    endtask

    // Divider starts at zero after reset; vsync steps move it exactly
    task automatic s_blink;
        cur = 1'b1;
        st(8'h0F, 4'h0, CAVS_EXT, 5'h00, {8'h00, 2'h0});
        st(8'h0F, 4'h0, CAVS_EXT, 5'h00, {8'hF0, 2'h3});
        vs(8);
        cur = 1'b0;
        st(8'h0F, 4'h0, CAVS_EXT, 5'h04, {8'h0F, 2'h0});
        vs(15);
        st(8'h0F, 4'h0, CAVS_EXT, 5'h04, {8'h0F, 2'h0});
        vs(1);
        st(8'h0F, 4'h0, CAVS_EXT, 5'h04, {8'h00, 2'h0});
        vs(8);
        st(8'h00, 4'h0, CAVS_EXT, 5'h00, {8'h0F, 2'h0});
    endtask

    // One record waits; fifteen more fill it, the sixteenth is dropped
    task automatic s_fifo;
        int i;
        logic [7:0] e;
        for (i = 0; i < 16; i++) begin
            code = 8'h10 + 8'(i);
            cavs_ctrl_model_i.push_only();
        end
        repeat (4) @(negedge ref_clk);
        ok({9'h000, ready}, 10'h000);
        for (i = 0; i < 17; i++) begin
            e = (i == 0) ? 8'h00 : (i < 16) ? 8'h0F + 8'(i) : 8'hC0;
            st(8'hC0 + 8'(i), 4'h0, CAVS_EXT, 5'h00, {e, 2'h0});
        end
    endtask

    initial begin
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        s_reset();
        s_ext();
        s_alpha();
        s_graph();
        s_attr();
        s_latch();
        s_blink();
        s_fifo();
        test_done();
    end
endmodule
